// *** hdl/gcr_top.sv ***
// global clock select, reset hooks, line power controls and interrupt tree
`timescale 1ns/1ps
`default_nettype none
`include "gcr_cfg.svh"
module gcr_top
	import gcr_pkg::*;
(
	input  wire logic                   mclk,
	input  wire logic                   rst,
	input  wire logic                   device_reset_n,
	input  wire logic                   scan_port_reset_n,
	input  wire gcr_sel_t               aux_clock_freq_select,
	input  wire logic [`GCR_PORTS-1:0]  line_standard_select,
	input  wire logic                   clock_ctrl_wr,
	input  wire logic                   global_soft_reset_wr,
	input  wire logic [`GCR_PORTS-1:0]  rx_framer_mode_wr,
	input  wire logic [`GCR_PORTS-1:0]  tx_framer_mode_wr,
	input  wire logic [`GCR_PORTS-1:0]  rx_hdlc_ctrl_wr,
	input  wire logic [`GCR_PORTS-1:0]  tx_hdlc_ctrl_wr,
	input  wire logic [`GCR_PORTS-1:0]  rx_elastic_ctrl_wr,
	input  wire logic [`GCR_PORTS-1:0]  tx_elastic_ctrl_wr,
	input  wire logic [`GCR_PORTS-1:0]  rx_code_ctrl_wr,
	input  wire logic [7:0]             wr_data,
	input  wire logic [`GCR_PORTS-1:0]  loop_up_code_wr,
	input  wire logic [`GCR_PORTS-1:0]  loop_down_code_wr,
	input  wire logic [`GCR_PORTS-1:0]  spare_code_wr,
	input  wire logic [`GCR_PORTS-1:0]  line_driver_power_down,
	input  wire logic [`GCR_PORTS-1:0]  line_receiver_power_down,
	input  wire logic [`GCR_PORTS-1:0]  line_driver_output_enable,
	input  wire logic [`GCR_PORTS-1:0]  line_data_pos,
	input  wire logic [`GCR_PORTS-1:0]  line_data_neg,
	input  wire logic [`GCR_PORTS*`GCR_STAT_W-1:0] tx_events,
	input  wire logic [`GCR_PORTS*`GCR_STAT_W-1:0] rx_events,
	input  wire logic [`GCR_PORTS*`GCR_STAT_W-1:0] line_events,
	input  wire logic [`GCR_PORTS*`GCR_STAT_W-1:0] tester_events,
	input  wire logic [`GCR_PORTS*`GCR_STAT_W-1:0] tx_mask,
	input  wire logic [`GCR_PORTS*`GCR_STAT_W-1:0] rx_mask,
	input  wire logic [`GCR_PORTS*`GCR_STAT_W-1:0] line_mask,
	input  wire logic [`GCR_PORTS*`GCR_STAT_W-1:0] tester_mask,
	input  wire logic [3:0]             clr_sel,
	input  wire logic [`GCR_PORTS-1:0]  clr_port,
	input  wire logic [`GCR_STAT_W-1:0] clr_data,
	output logic                        aux_clock_out,
	output logic                        scan_reset,
	output logic                        settle_busy,
	output logic [`GCR_PORTS-1:0]       framer_reset,
	output logic [`GCR_PORTS-1:0]       line_reset,
	output logic [`GCR_PORTS-1:0]       tester_reset,
	output logic [`GCR_PORTS-1:0]       rx_framer_reset,
	output logic [`GCR_PORTS-1:0]       tx_framer_reset,
	output logic [`GCR_PORTS-1:0]       rx_hdlc_reset,
	output logic [`GCR_PORTS-1:0]       tx_hdlc_reset,
	output logic [`GCR_PORTS-1:0]       rx_elastic_reset,
	output logic [`GCR_PORTS-1:0]       tx_elastic_reset,
	output logic [`GCR_PORTS-1:0]       rx_code_reset,
	output logic [`GCR_PORTS-1:0]       loop_code_restart,
	output logic [`GCR_PORTS-1:0]       spare_code_restart,
	output logic [`GCR_PORTS-1:0]       tx_powered,
	output logic [`GCR_PORTS-1:0]       rx_powered,
	output logic [`GCR_PORTS-1:0]       line_out_pos,
	output logic [`GCR_PORTS-1:0]       line_out_neg,
	output logic [`GCR_PORTS-1:0]       line_out_oe,
	output logic [`GCR_PORTS-1:0]       global_framer_irq_info,
	output logic [`GCR_PORTS-1:0]       global_line_irq_info,
	output logic [`GCR_PORTS-1:0]       global_tester_irq_info,
	output logic [`GCR_PORTS-1:0]       tx_irq_info_reg,
	output logic [`GCR_PORTS-1:0]       rx_irq_info_reg,
	output logic [`GCR_PORTS*`GCR_STAT_W-1:0] tx_latched_status,
	output logic [`GCR_PORTS*`GCR_STAT_W-1:0] rx_latched_status,
	output logic [`GCR_PORTS*`GCR_STAT_W-1:0] line_latched_status,
	output logic [`GCR_PORTS*`GCR_STAT_W-1:0] tester_latched_status,
	output logic                        irq_out_n,
	output logic                        irq_out_oe
);
	localparam logic [2:0] PULSE_LAST = 3'(`GCR_RST_PULSE_CYC - 1);
	localparam logic [3:0] SETTLE_LAST = 4'(`GCR_SETTLE_CYC - 1);

	// pin synchronisers: first stage read only by the second
	logic       dev_rst_s1_q;
	logic       dev_rst_s2_q;
	logic       scan_rst_s1_q;
	logic       scan_rst_s2_q;
	logic       dev_reset_now;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			dev_rst_s1_q  <= 1'b0;
			dev_rst_s2_q  <= 1'b0;
			scan_rst_s1_q <= 1'b0;
			scan_rst_s2_q <= 1'b0;
		end else begin
			dev_rst_s1_q  <= device_reset_n;
			dev_rst_s2_q  <= dev_rst_s1_q;
			scan_rst_s1_q <= scan_port_reset_n;
			scan_rst_s2_q <= scan_rst_s1_q;
		end
	end

	// pin low holds the framer, line and tester blocks in reset and powers down the drivers
	assign dev_reset_now = ~dev_rst_s2_q;

	// scan port reset separate from device reset
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			scan_reset <= 1'b1;
		else
			scan_reset <= ~scan_rst_s2_q;
	end

	// global soft reset sequencer: stretched pulse, so slow logic sees it
	gcr_rst_e   st_q;
	gcr_rst_e   st_d;
	logic [2:0] pulse_cnt_q;
	logic [3:0] settle_cnt_q;
	logic       glob_pulse;

	always_comb begin
		st_d = st_q;
		case (st_q)
			GCR_IDLE: begin
				// any write to the global register starts a reset
				if (global_soft_reset_wr)
					st_d = GCR_PULSE;
				else if (clock_ctrl_wr)
					st_d = GCR_SETTLE;
			end
			GCR_PULSE: begin
				if (pulse_cnt_q == PULSE_LAST)
					st_d = GCR_IDLE;
			end
			GCR_SETTLE: begin
				if (global_soft_reset_wr)
					st_d = GCR_PULSE;
				else if (settle_cnt_q == SETTLE_LAST)
					st_d = GCR_IDLE;
			end
			default: st_d = GCR_IDLE;
		endcase
	end

	assign glob_pulse = (st_q == GCR_PULSE);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_q         <= GCR_IDLE;
			pulse_cnt_q  <= 3'h0;
			settle_cnt_q <= 4'h0;
		end else begin
			st_q         <= st_d;
			pulse_cnt_q  <= (st_q == GCR_PULSE) ? pulse_cnt_q + 3'h1 : 3'h0;
			settle_cnt_q <= (st_q == GCR_SETTLE) ? settle_cnt_q + 4'h1 : 4'h0;
		end
	end

	// clock settle window shown to the host, who must honour it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			settle_busy <= 1'b0;
		else
			settle_busy <= (st_d == GCR_SETTLE);
	end

	logic all_rst;
	assign all_rst = dev_reset_now | glob_pulse;

	// per-port reset hooks; strobes pulse only when their bit is written as one, code restarts pulse on any write
	logic [`GCR_PORTS-1:0] lreset_d;
	logic [`GCR_PORTS-1:0] tx_pd;
	logic [`GCR_PORTS-1:0] drive;

	genvar p;
	generate
		for (p = 0; p < `GCR_PORTS; p++) begin : g_port
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					framer_reset[p]       <= 1'b1;
					line_reset[p]         <= 1'b1;
					tester_reset[p]       <= 1'b1;
					rx_framer_reset[p]    <= 1'b0;
					tx_framer_reset[p]    <= 1'b0;
					rx_hdlc_reset[p]      <= 1'b0;
					tx_hdlc_reset[p]      <= 1'b0;
					rx_elastic_reset[p]   <= 1'b0;
					tx_elastic_reset[p]   <= 1'b0;
					rx_code_reset[p]      <= 1'b0;
					loop_code_restart[p]  <= 1'b0;
					spare_code_restart[p] <= 1'b0;
				end else begin
					// hardware reset and soft reset reach all three
					framer_reset[p]       <= all_rst;
					line_reset[p]         <= all_rst;
					tester_reset[p]       <= all_rst;
					rx_framer_reset[p]    <= rx_framer_mode_wr[p] & wr_data[`GCR_BIT_FRM_RST];
					tx_framer_reset[p]    <= tx_framer_mode_wr[p] & wr_data[`GCR_BIT_FRM_RST];
					rx_hdlc_reset[p]      <= rx_hdlc_ctrl_wr[p] & wr_data[`GCR_BIT_RHDLC_RST];
					tx_hdlc_reset[p]      <= tx_hdlc_ctrl_wr[p] & wr_data[`GCR_BIT_THDLC_RST];
					rx_elastic_reset[p]   <= rx_elastic_ctrl_wr[p] & wr_data[`GCR_BIT_ES_RST];
					tx_elastic_reset[p]   <= tx_elastic_ctrl_wr[p] & wr_data[`GCR_BIT_ES_RST];
					rx_code_reset[p]      <= rx_code_ctrl_wr[p] & wr_data[`GCR_BIT_BOC_RST];
					loop_code_restart[p]  <= loop_up_code_wr[p] | loop_down_code_wr[p];
					spare_code_restart[p] <= spare_code_wr[p];
				end
			end
		end
	endgenerate

	// power-down tristates and unpowers; enable clear only tristates
	assign tx_pd = line_driver_power_down | {`GCR_PORTS{all_rst}};
	assign drive = ~tx_pd & line_driver_output_enable;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tx_powered   <= '0;
			rx_powered   <= '0;
			line_out_pos <= '0;
			line_out_neg <= '0;
			line_out_oe  <= '0;
		end else begin
			tx_powered   <= ~tx_pd;
			rx_powered   <= ~line_receiver_power_down;
			line_out_pos <= line_data_pos & drive;
			line_out_neg <= line_data_neg & drive;
			line_out_oe  <= drive;
		end
	end

	// interrupt tree: four latched groups per port
	logic [`GCR_PORTS-1:0] info_tx;
	logic [`GCR_PORTS-1:0] info_rx;
	logic [`GCR_PORTS-1:0] info_ln;
	logic [`GCR_PORTS-1:0] info_bt;

	generate
		for (p = 0; p < `GCR_PORTS; p++) begin : g_irq
			gcr_port_irq u_tx (
				.mclk    (mclk),
				.rst     (rst),
				.events  (tx_events[p*`GCR_STAT_W +: `GCR_STAT_W]),
				.clr_w1c (clr_data),
				.clr_we  (clr_port[p] & clr_sel[0]),
				.mask    (tx_mask[p*`GCR_STAT_W +: `GCR_STAT_W]),
				.latched (tx_latched_status[p*`GCR_STAT_W +: `GCR_STAT_W]),
				.info    (info_tx[p])
			);
			gcr_port_irq u_rx (
				.mclk    (mclk),
				.rst     (rst),
				.events  (rx_events[p*`GCR_STAT_W +: `GCR_STAT_W]),
				.clr_w1c (clr_data),
				.clr_we  (clr_port[p] & clr_sel[1]),
				.mask    (rx_mask[p*`GCR_STAT_W +: `GCR_STAT_W]),
				.latched (rx_latched_status[p*`GCR_STAT_W +: `GCR_STAT_W]),
				.info    (info_rx[p])
			);
			gcr_port_irq u_ln (
				.mclk    (mclk),
				.rst     (rst),
				.events  (line_events[p*`GCR_STAT_W +: `GCR_STAT_W]),
				.clr_w1c (clr_data),
				.clr_we  (clr_port[p] & clr_sel[2]),
				.mask    (line_mask[p*`GCR_STAT_W +: `GCR_STAT_W]),
				.latched (line_latched_status[p*`GCR_STAT_W +: `GCR_STAT_W]),
				.info    (info_ln[p])
			);
			gcr_port_irq u_bt (
				.mclk    (mclk),
				.rst     (rst),
				.events  (tester_events[p*`GCR_STAT_W +: `GCR_STAT_W]),
				.clr_w1c (clr_data),
				.clr_we  (clr_port[p] & clr_sel[3]),
				.mask    (tester_mask[p*`GCR_STAT_W +: `GCR_STAT_W]),
				.latched (tester_latched_status[p*`GCR_STAT_W +: `GCR_STAT_W]),
				.info    (info_bt[p])
			);
		end
	endgenerate

	logic any_pending;
	// global bits are or of per-port info
	assign any_pending = |(info_tx | info_rx | info_ln | info_bt);

	// one global bit per port; refreshed every cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tx_irq_info_reg        <= '0;
			rx_irq_info_reg        <= '0;
			global_framer_irq_info <= '0;
			global_line_irq_info   <= '0;
			global_tester_irq_info <= '0;
			irq_out_n              <= 1'b0;
			irq_out_oe             <= 1'b0;
		end else begin
			tx_irq_info_reg        <= info_tx;
			rx_irq_info_reg        <= info_rx;
			global_framer_irq_info <= info_tx | info_rx;
			global_line_irq_info   <= info_ln;
			global_tester_irq_info <= info_bt;
			// open drain: pull low only when pending
			irq_out_n              <= 1'b0;
			irq_out_oe             <= any_pending;
		end
	end

	gcr_aux_clk u_aux (
		.mclk                 (mclk),
		.rst                  (rst),
		.sel                  (aux_clock_freq_select),
		.line_standard_select (line_standard_select[0]),
		.aux_clock_out        (aux_clock_out)
	);
endmodule // gcr_top
`default_nettype wire

// *** shared/gcr_cfg.svh ***
// constants for the global clock, reset and interrupt control block
`ifndef GCR_CFG_SVH
`define GCR_CFG_SVH
`define GCR_PORTS          8
`define GCR_STAT_W         8
`define GCR_SEL_W          4
`define GCR_MCLK_HZ        25000000
`define GCR_SETTLE_NS      300
`define GCR_SETTLE_CYC     ((`GCR_SETTLE_NS * (`GCR_MCLK_HZ / 1000000) + 999) / 1000)
`define GCR_RST_PULSE_CYC  4
`define GCR_BIT_FRM_RST    1
`define GCR_BIT_RHDLC_RST  6
`define GCR_BIT_THDLC_RST  5
`define GCR_BIT_ES_RST     2
`define GCR_BIT_BOC_RST    7
`define GCR_ACC_W          16
`endif

// *** shared/gcr_pkg.sv ***
// types for the global clock, reset and interrupt control block
package gcr_pkg;
	typedef enum logic [1:0] {
		GCR_IDLE   = 2'b00,
		GCR_PULSE  = 2'b01,
		GCR_SETTLE = 2'b11
	} gcr_rst_e;
	typedef logic [3:0] gcr_sel_t;
endpackage

// *** hdl/gcr_aux_clk.sv ***
// auxiliary output clock synthesis directly from the master clock
`timescale 1ns/1ps
`default_nettype none
`include "gcr_cfg.svh"
module gcr_aux_clk
	import gcr_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire gcr_sel_t              sel,
	input  wire logic                  line_standard_select,
	output logic                       aux_clock_out
);
	// phase accumulator stands in for the synthesis pll; clocked directly by mclk, no prescaler
	logic [`GCR_ACC_W-1:0] acc_q;
	logic [`GCR_ACC_W-1:0] step;
	logic [15:0]           khz;
	logic [15:0]           scaled;

	function automatic logic [15:0] sel_khz(input gcr_sel_t s);
		case (s)
			4'h0: sel_khz = 16'd2048;
			4'h1: sel_khz = 16'd4096;
			4'h2: sel_khz = 16'd8192;
			4'h3: sel_khz = 16'd16384;
			4'h4: sel_khz = 16'd1544;
			4'h5: sel_khz = 16'd3088;
			4'h6: sel_khz = 16'd6176;
			4'h7: sel_khz = 16'd12352;
			4'h8: sel_khz = 16'd1536;
			4'h9: sel_khz = 16'd3072;
			4'ha: sel_khz = 16'd6144;
			4'hb: sel_khz = 16'd12288;
			4'hc: sel_khz = 16'd32;
			4'hd: sel_khz = 16'd64;
			4'he: sel_khz = 16'd128;
			default: sel_khz = 16'd256;
		endcase
	endfunction

	assign khz = sel_khz(sel);
	// line standard select has no effect, both arms give the same step; raw mclk, no prescaler
	// limitation: at 25 MHz only rates below 12.5 MHz are exact on average
	// wraps per ms match the rate in khz; truncation costs far less than one edge
	assign scaled = 16'((32'(khz) << 16) / 32'(`GCR_MCLK_HZ / 1000));
	assign step   = line_standard_select ? scaled : scaled;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			acc_q         <= 16'h0000;
			aux_clock_out <= 1'b0;
		end else begin
			acc_q         <= acc_q + step;
			aux_clock_out <= acc_q[`GCR_ACC_W-1];
		end
	end
endmodule // gcr_aux_clk
`default_nettype wire

// *** hdl/gcr_port_irq.sv ***
// one port's latched status, mask and live information bit
`timescale 1ns/1ps
`default_nettype none
`include "gcr_cfg.svh"
module gcr_port_irq (
	input  wire logic                   mclk,
	input  wire logic                   rst,
	input  wire logic [`GCR_STAT_W-1:0] events,
	input  wire logic [`GCR_STAT_W-1:0] clr_w1c,
	input  wire logic                   clr_we,
	input  wire logic [`GCR_STAT_W-1:0] mask,
	output logic      [`GCR_STAT_W-1:0] latched,
	output logic                        info
);
	logic [`GCR_STAT_W-1:0] clr_eff;
	logic [`GCR_STAT_W-1:0] latched_d;

	// one clears, zero leaves alone; a new event beats the clear
	assign clr_eff   = clr_we ? clr_w1c : '0;
	assign latched_d = (latched & ~clr_eff) | events;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			latched <= '0;
		else
			latched <= latched_d;
	end

	// masked bits still latch but stay out of info
	// info is or of unmasked latched bits; live, not latched
	assign info = |(latched & ~mask);
endmodule // gcr_port_irq
`default_nettype wire

// *** sim/gcr_chk_sva.sv ***
// port assertions for the global clock, reset and interrupt block
`timescale 1ns/1ps
`default_nettype none
module gcr_chk_sva (
	input wire logic        mclk, rst, device_reset_n, scan_port_reset_n, scan_reset,
	input wire logic        global_soft_reset_wr, clock_ctrl_wr, settle_busy, irq_out_n,
	input wire logic        irq_out_oe,
	input wire logic [3:0]  clr_sel,
	input wire logic [7:0]  wr_data, clr_port, clr_data, rx_framer_mode_wr, rx_framer_reset,
	input wire logic [7:0]  rx_hdlc_ctrl_wr, rx_hdlc_reset, tx_hdlc_ctrl_wr, tx_hdlc_reset,
	input wire logic [7:0]  loop_up_code_wr, loop_down_code_wr, loop_code_restart,
	input wire logic [7:0]  framer_reset, line_reset, tester_reset, line_out_oe,
	input wire logic [7:0]  line_driver_power_down, line_driver_output_enable,
	input wire logic [7:0]  tx_irq_info_reg, rx_irq_info_reg, global_framer_irq_info,
	input wire logic [7:0]  global_line_irq_info, global_tester_irq_info,
	input wire logic [63:0] tx_events, tx_mask, tx_latched_status
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// port 2 bit 3 of the transmit status is the watched bit
	wire clr_hit = clr_sel[0] && clr_port[2] && clr_data[3];
	sequence soft_pulse;
		framer_reset[0] [*4] ##1 !framer_reset[0];
	endsequence
	sequence settle_win;
		settle_busy [*8] ##1 !settle_busy;
	endsequence
	chk_framer_strobe: assert property (rx_framer_reset == $past(rx_framer_mode_wr & {8{wr_data[1]}}))
		else $error("framer reset strobe wrong");
	chk_hdlc_strobe: assert property (rx_hdlc_reset == $past(rx_hdlc_ctrl_wr & {8{wr_data[6]}})
		&& tx_hdlc_reset == $past(tx_hdlc_ctrl_wr & {8{wr_data[5]}})) else $error("hdlc reset strobe wrong");
	chk_code_restart: assert property (loop_code_restart == $past(loop_up_code_wr | loop_down_code_wr))
		else $error("loop code restart wrong");
	chk_soft_pulse: assert property (global_soft_reset_wr && !$past(global_soft_reset_wr)
		&& framer_reset == 8'h00 && device_reset_n |-> ##2 soft_pulse) else $error("soft reset pulse");
	chk_settle_window: assert property (clock_ctrl_wr && !settle_busy && !$past(clock_ctrl_wr)
		|=> settle_win) else $error("settle window length");
	chk_hw_reset: assert property (!device_reset_n [*4] |-> framer_reset == 8'hff
		&& line_reset == 8'hff && tester_reset == 8'hff) else $error("hardware reset missing");
	chk_scan_reset: assert property (!scan_port_reset_n [*4] |-> scan_reset)
		else $error("scan reset missing");
	chk_line_enable: assert property (!line_reset[0] && !$past(line_reset[0]) |-> line_out_oe[0]
		== $past(!line_driver_power_down[0] && line_driver_output_enable[0])) else $error("line oe");
	chk_latch_set: assert property (tx_events[19] |=> tx_latched_status[19])
		else $error("status did not latch");
	chk_latch_hold: assert property (tx_latched_status[19] && !clr_hit && framer_reset == 8'h00
		|=> tx_latched_status[19]) else $error("status lost");
	chk_latch_clear: assert property (clr_hit && !tx_events[19] |=> !tx_latched_status[19])
		else $error("status not cleared");
	chk_port_info: assert property (tx_irq_info_reg[2]
		== $past(|(tx_latched_status[23:16] & ~tx_mask[23:16]))) else $error("port info wrong");
	chk_global_info: assert property (global_framer_irq_info == (tx_irq_info_reg | rx_irq_info_reg))
		else $error("global info wrong");
	chk_irq_pin: assert property (irq_out_n == 1'b0 && irq_out_oe
		== |{global_framer_irq_info, global_line_irq_info, global_tester_irq_info}) else $error("irq pin");
endmodule // gcr_chk_sva
`default_nettype wire

// *** sim/gcr_host_model.sv ***
// host model: clock control write, then hold off until settled
`timescale 1ns/1ps
`default_nettype none
module gcr_host_model (
	input  wire logic mclk,
	input  wire logic go,
	input  wire logic settle_busy,
	output logic      clock_ctrl_wr,
	output logic      done
);
	initial begin
		clock_ctrl_wr = 1'b0;
		done = 1'b0;
		forever begin
			@(posedge mclk);
			if (go) begin
				done = 1'b0;
				#1 clock_ctrl_wr = 1'b1;
				@(posedge mclk);
				#1 clock_ctrl_wr = 1'b0;
				@(posedge mclk);
				#1;
				// no access until the settle window closes
				for (int n = 0; n < 20 && settle_busy !== 1'b0; n++) begin
					@(posedge mclk);
					#1;
				end
				// done holds until the next request so the bench cannot miss it
				done = 1'b1;
			end
		end
	end
endmodule // gcr_host_model
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench for the global clock, reset and interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import gcr_pkg::*;
	logic rst = 1'b1, device_reset_n = 1'b1, scan_port_reset_n = 1'b1, go = 1'b0;
	logic global_soft_reset_wr = 1'b0, mclk, clock_ctrl_wr, done;
	gcr_sel_t aux_clock_freq_select = '0;
	logic [3:0] clr_sel = '0;
	logic [7:0] wr_data = '0, clr_port = '0, clr_data = '0, line_standard_select = '0;
	logic [7:0] rx_framer_mode_wr = '0, tx_framer_mode_wr = '0, rx_hdlc_ctrl_wr = '0;
	logic [7:0] tx_hdlc_ctrl_wr = '0, rx_elastic_ctrl_wr = '0, tx_elastic_ctrl_wr = '0;
	logic [7:0] rx_code_ctrl_wr = '0, loop_up_code_wr = '0, loop_down_code_wr = '0;
	logic [7:0] spare_code_wr = '0, line_driver_power_down = '0, line_receiver_power_down = '0;
	logic [7:0] line_driver_output_enable = '0, line_data_pos = '0, line_data_neg = '0;
	logic [63:0] tx_events = '0, rx_events = '0, line_events = '0, tester_events = '0;
	logic [63:0] tx_mask = '0, rx_mask = '0, line_mask = '0, tester_mask = '0;
	logic scan_reset, settle_busy, irq_out_n, irq_out_oe, aux_clock_out;
	logic [7:0] framer_reset, line_reset, tester_reset, rx_framer_reset, tx_framer_reset;
	logic [7:0] rx_hdlc_reset, tx_hdlc_reset, rx_elastic_reset, tx_elastic_reset, rx_code_reset;
	logic [7:0] loop_code_restart, spare_code_restart, tx_powered, rx_powered, line_out_pos;
	logic [7:0] line_out_neg, line_out_oe, global_framer_irq_info, global_line_irq_info;
	logic [7:0] global_tester_irq_info, tx_irq_info_reg, rx_irq_info_reg;
	logic [63:0] tx_latched_status, rx_latched_status, line_latched_status, tester_latched_status;
	int num_errors = 0;
	int tests_run = 0;
	gcr_top DUT (.*);
	gcr_host_model host (.mclk(mclk), .go(go), .settle_busy(settle_busy),
		.clock_ctrl_wr(clock_ctrl_wr), .done(done));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic tick(int n = 1);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic waited(string name, int n);
		chk(name, n < 20, 1'b1);
		if (n >= 20) final_report();
	endtask
	function automatic logic [7:0] hit(bit c);
		return c ? 8'h09 : 8'h00;
	endfunction
	// back-to-back strobes, one data bit at a time
	task automatic t_strobes;
		{rx_framer_mode_wr, tx_framer_mode_wr, rx_hdlc_ctrl_wr, tx_hdlc_ctrl_wr,
			rx_elastic_ctrl_wr, tx_elastic_ctrl_wr, rx_code_ctrl_wr} = {7{8'h09}};
		for (int b = 0; b < 8; b++) begin
			wr_data = 8'h01 << b;
			tick();
			chk("strobe_resets", {rx_framer_reset, tx_framer_reset, rx_hdlc_reset, tx_hdlc_reset,
				rx_elastic_reset, tx_elastic_reset, rx_code_reset}, {hit(b == 1), hit(b == 1),
				hit(b == 6), hit(b == 5), hit(b == 2), hit(b == 2), hit(b == 7)});
		end
		{rx_framer_mode_wr, tx_framer_mode_wr, rx_hdlc_ctrl_wr, tx_hdlc_ctrl_wr,
			rx_elastic_ctrl_wr, tx_elastic_ctrl_wr, rx_code_ctrl_wr} = '0;
		tick();
		chk("strobe_release", {rx_framer_reset, tx_hdlc_reset, rx_code_reset}, 0);
		loop_up_code_wr = 8'h20;
		loop_down_code_wr = 8'h04;
		spare_code_wr = 8'h80;
		tick();
		{loop_up_code_wr, loop_down_code_wr, spare_code_wr} = '0;
		chk("code_restart", {loop_code_restart, spare_code_restart}, 16'h2480);
		tick();
		chk("code_restart_end", {loop_code_restart, spare_code_restart}, 0);
	endtask
	// soft reset pulse, second write during it ignored
	task automatic t_soft;
		int n = 0;
		global_soft_reset_wr = 1'b1;
		tick();
		global_soft_reset_wr = 1'b0;
		chk("soft_delay", framer_reset, 8'h00);
		for (int i = 0; i < 12; i++) begin
			global_soft_reset_wr = (i == 2);
			tick();
			if ({framer_reset, line_reset, tester_reset} === 24'hffffff) n++;
		end
		chk("soft_len", n, 4);
	endtask
	// power-down and driver enable per port
	task automatic t_line;
		line_driver_power_down = 8'h0f;
		line_driver_output_enable = 8'h33;
		line_receiver_power_down = 8'h55;
		line_data_pos = 8'hff;
		line_data_neg = 8'h1f;
		tick(2);
		chk("line_oe", line_out_oe, 8'h30);
		chk("tx_powered", tx_powered, 8'hf0);
		chk("rx_powered", rx_powered, 8'haa);
		chk("line_data", {line_out_pos, line_out_neg}, 16'h3010);
	endtask
	task automatic t_irq;
		tx_mask = 64'h80000;
		tx_events[19] = 1'b1;
		rx_events[0] = 1'b1;
		line_events[48] = 1'b1;
		tester_events[9] = 1'b1;
		tick();
		{tx_events, rx_events, line_events, tester_events} = '0;
		tick(2);
		chk("masked_latch", tx_latched_status, 64'h80000);
		chk("masked_info", tx_irq_info_reg, 8'h00);
		chk("rx_info", rx_irq_info_reg, 8'h01);
		chk("globals", {global_framer_irq_info, global_line_irq_info, global_tester_irq_info},
			24'h014002);
		chk("irq_pin", irq_out_oe, 1'b1);
		clr_sel = 4'b1110;
		clr_port = 8'h43;
		clr_data = 8'h03;
		tick();
		{clr_sel, clr_port, clr_data} = '0;
		tick(2);
		chk("others_clear", {rx_latched_status, line_latched_status, tester_latched_status}, 0);
		chk("only_masked", {global_framer_irq_info, irq_out_oe}, 0);
		tx_mask = '0;
		tick(2);
		chk("unmasked", {tx_irq_info_reg, global_framer_irq_info, irq_out_oe}, 17'h00809);
		for (int k = 0; k < 3; k++) begin
			clr_sel = 4'h1;
			clr_port = 8'h04;
			clr_data = (k == 0) ? 8'hf7 : 8'h08;
			tx_events[19] = (k == 1);
			tick();
			{clr_sel, clr_port, clr_data} = '0;
			tx_events = '0;
			tick(2);
			chk("w1c", tx_latched_status, (k == 2) ? 64'h0 : 64'h80000);
		end
		chk("info_live", {tx_irq_info_reg, irq_out_oe, irq_out_n}, 0);
	endtask
	// host write of clock control, then settle wait
	task automatic t_clk;
		int n = 0;
		go = 1'b1;
		tick();
		go = 1'b0;
		while (done !== 1'b1 && n < 20) begin
			tick();
			n++;
		end
		waited("settle_wait", n);
		chk("settle_len", n >= 8, 1'b1);
	endtask
	// hardware and scan resets stay independent
	task automatic t_pins;
		int n = 0;
		device_reset_n = 1'b0;
		tick(5);
		chk("hw_reset", {framer_reset, line_reset, tester_reset, scan_reset}, 25'h1fffffe);
		device_reset_n = 1'b1;
		scan_port_reset_n = 1'b0;
		while (framer_reset !== 8'h00 && n < 20) begin
			tick();
			n++;
		end
		waited("hw_release", n);
		tick(5);
		chk("scan_only", {scan_reset, framer_reset}, 9'h100);
		scan_port_reset_n = 1'b1;
		tick(5);
		chk("scan_release", scan_reset, 1'b0);
	endtask
	// edge count over 2500 cycles, codes above half the clock rate skipped
	task automatic t_aux;
		int khz[16] = '{2048, 4096, 8192, 16384, 1544, 3088, 6176, 12352,
			1536, 3072, 6144, 12288, 32, 64, 128, 256};
		int n;
		logic last;
		for (int s = 0; s < 16; s++) begin
			aux_clock_freq_select = gcr_sel_t'(s);
			line_standard_select = (s >= 4 && s < 12) ? 8'hff : 8'h00;
			tick(20);
			n = 0;
			last = aux_clock_out;
			for (int i = 0; i < 2500; i++) begin
				tick();
				if (aux_clock_out === 1'b1 && last === 1'b0) n++;
				last = aux_clock_out;
			end
			if (khz[s] < 12500) chk("aux_rate", (n - khz[s] / 10) inside {[-2:2]}, 1'b1);
		end
	endtask
	initial begin
		// every control input except rst starts inactive (the active-low resets at one) and only its own task sets it
		// line and irq enables are applied after the strobe setup
		tick(5);
		rst = 1'b0;
		tick(4);
		t_strobes();
		t_soft();
		t_line();
		t_irq();
		t_clk();
		t_pins();
		t_aux();
		final_report();
	end
endmodule // tb_top
bind gcr_top gcr_chk_sva u_chk (.*);
`default_nettype wire
